// ---- core/rst_wdt_pkg.sv ----
package rst_wdt_pkg;

   // ************************************************************
   // register map and field layout
   // ************************************************************
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'h00;
   localparam logic [7:0] ADDR_WDT_CTRL    = 8'h04;

   localparam int CAUSE_POR = 0;
   localparam int CAUSE_EXT = 1;
   localparam int CAUSE_BOD = 2;
   localparam int CAUSE_WDT = 3;

   localparam int CTRL_FLAG  = 7;
   localparam int CTRL_IRQEN = 6;
   localparam int CTRL_WDP3  = 5;
   localparam int CTRL_CHG   = 4;
   localparam int CTRL_WDE   = 3;

   localparam logic [3:0] RESET_CAUSE_INIT = 4'h1;
   localparam logic [3:0] WDP_INIT         = 4'h0;
   localparam logic [3:0] WDP_MAX          = 4'h9;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS     = 10;
   localparam int WDT_OSC_HZ        = 128000;
   localparam int EXT_MIN_PULSE_NS  = 2500;
   localparam logic [7:0] EXT_MIN_PULSE_CYC =
      8'((EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] UNLOCK_WINDOW       = 3'h4;
   localparam logic [15:0] RELEASE_BASE_CYCLES = 16'h0040;
   localparam int WDT_BASE_CYCLES   = 2048;

   localparam logic [2:0] BOD_OFF = 3'h7;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      RS_HOLD,
      RS_DELAY,
      RS_RUN
   } seq_state_t;

endpackage

// ---- core/system_reset_and_watchdog.sv ----
`timescale 1ns/1ps

// What this block does
// - while reset holds, I/O registers go to init; release starts at vector
// - port pins forced to initial state as soon as any source is active
// - reset stretched by a delay chosen by startup and clock fuses
// - four sources: power-on, reset pin, watchdog, enabled brown-out
// - reset pin low longer than minimum pulse width causes reset
// - reset pin rising starts the delay; release after it expires
// - reset pin ignored when the pin-disable fuse is programmed
// - power-on low reasserts reset at once; rising starts the delay
// - enabled brown-out asserts reset at once; release after delay
// - watchdog reset is a one-cycle pulse; delay starts as it falls
// - voltage reference on only for brown-out, bandgap select or converter
// - watchdog counts its own oscillator cycles up to selected value
// - restart instruction clears the watchdog count
// - interrupt mode expiry raises a wake-capable interrupt, no reset
// - system-reset mode expiry resets the system
// - combined mode: first expiry interrupts, later expiry resets
// - always-on fuse forces reset mode, enable reads 1, irq enable 0
// - reset-enable clear or prescaler change accepted only in window
// - time-out selectable from about 16 ms to about 8 s
// - change-enable clears itself four cycles after being set
// - reset-enable held set while watchdog reset flag is set
// - each source sets its cause flag; clear rules per flag
module system_reset_and_watchdog
#(
   parameter int WDT_BASE = rst_wdt_pkg::WDT_BASE_CYCLES,
   parameter int WDT_CW   = 21
)
(
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_power_low,
   input  wire logic        i_reset_pin_n,
   input  wire logic        i_brownout_low,
   input  wire logic [1:0]  i_startup_time_fuse,
   input  wire logic [3:0]  i_clock_select_fuse,
   input  wire logic        i_reset_pin_disable_fuse,
   input  wire logic [2:0]  i_brownout_level_fuse,
   input  wire logic        i_watchdog_always_on_fuse,
   input  wire logic        i_comparator_bandgap_select,
   input  wire logic        i_adc_enable,
   input  wire logic        i_wdt_osc,
   input  wire logic        i_wdt_restart,
   input  wire logic        i_wdt_irq_ack,
   output logic             o_core_reset,
   output logic             o_port_reset,
   output logic             o_wdt_irq,
   output logic             o_vref_enable
);

   // ************************************************************
   // declarations
   // ************************************************************
   logic                    bod_en;
   logic                    bod_hit;
   logic [7:0]              ext_low_cnt;
   logic                    ext_active;
   logic                    wdt_rst_pulse;
   logic                    src_active;
   rst_wdt_pkg::seq_state_t state;
   rst_wdt_pkg::seq_state_t next_state;
   logic [15:0]             delay_cnt;
   logic [15:0]             release_cycles;
   logic [2:0]              release_shift;
   logic [3:0]              cause;
   logic [3:0]              cause_set;
   logic                    wr_commit;
   logic                    wr_cause;
   logic                    wr_ctrl;
   logic [7:0]              wd;
   logic                    flag;
   logic                    irq_en;
   logic                    watchdog_reset_enable;
   logic [3:0]              watchdog_prescaler;
   logic                    chg_en;
   logic [2:0]              win_cnt;
   logic                    unlock_wr;
   logic                    wde_eff;
   logic                    irq_en_eff;
   logic                    osc_q;
   logic                    osc_edge;
   logic                    running;
   logic [3:0]              wdp_sel;
   logic [WDT_CW-1:0]       wdt_cnt;
   logic [WDT_CW-1:0]       wdt_limit;
   logic                    timeout;
   logic                    set_flag;
   logic                    rst_hit;
   logic                    next_flag;
   logic [7:0]              rd_byte;

   // ************************************************************
   // reset sources
   // ************************************************************
   assign bod_en  = i_brownout_level_fuse != rst_wdt_pkg::BOD_OFF;
   assign bod_hit = bod_en & i_brownout_low;

   // spike filter: short low pulses on the pin are dropped
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         ext_low_cnt <= 8'h00;
         ext_active  <= 1'b0;
      end
      else if (i_ce)
      begin
         if (i_reset_pin_disable_fuse || i_reset_pin_n)
         begin
            ext_low_cnt <= 8'h00;
            ext_active  <= 1'b0;
         end
         else if (ext_low_cnt == rst_wdt_pkg::EXT_MIN_PULSE_CYC)
         begin
            ext_active <= 1'b1;
         end
         else
         begin
            ext_low_cnt <= ext_low_cnt + 8'h01;
         end
      end
   end

   assign src_active = i_power_low | ext_active | bod_hit
                       | wdt_rst_pulse;

   // ************************************************************
   // release delay sequencer
   // ************************************************************
   assign release_shift  = 3'({1'b0, i_startup_time_fuse})
                         + 3'({1'b0, i_clock_select_fuse[1:0]});
   assign release_cycles = rst_wdt_pkg::RELEASE_BASE_CYCLES
                         << release_shift;

   always_comb
   begin
      next_state = state;
      case (state)
         rst_wdt_pkg::RS_HOLD:
         begin
            if (!src_active)
               next_state = rst_wdt_pkg::RS_DELAY;
         end
         rst_wdt_pkg::RS_DELAY:
         begin
            if (src_active)
               next_state = rst_wdt_pkg::RS_HOLD;
            else if (delay_cnt == release_cycles - 16'h0001)
               next_state = rst_wdt_pkg::RS_RUN;
         end
         rst_wdt_pkg::RS_RUN:
         begin
            if (src_active)
               next_state = rst_wdt_pkg::RS_HOLD;
         end
         default:
         begin
            next_state = rst_wdt_pkg::RS_HOLD;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         state        <= rst_wdt_pkg::RS_HOLD;
         delay_cnt    <= 16'h0000;
         o_core_reset <= 1'b1;
         o_port_reset <= 1'b1;
      end
      else if (i_ce)
      begin
         state        <= next_state;
         // pins follow the sources directly, not the stretched reset
         o_port_reset <= src_active;
         // core leaves reset only from RS_RUN, i.e. at the vector
         o_core_reset <= next_state != rst_wdt_pkg::RS_RUN;
         if (next_state == rst_wdt_pkg::RS_DELAY)
            delay_cnt <= delay_cnt + 16'h0001;
         else
            delay_cnt <= 16'h0000;
      end
   end

   // ************************************************************
   // wishbone slave
   // ************************************************************
   // writes land on the ack edge so the master sees them then
   assign wr_commit = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack
                      & i_wb_sel[0];
   assign wr_cause  = wr_commit
                      & (i_wb_adr == rst_wdt_pkg::ADDR_RESET_CAUSE);
   assign wr_ctrl   = wr_commit
                      & (i_wb_adr == rst_wdt_pkg::ADDR_WDT_CTRL);
   assign wd        = i_wb_dat[7:0];

   always_comb
   begin
      rd_byte = 8'h00;
      if (i_wb_adr == rst_wdt_pkg::ADDR_RESET_CAUSE)
         rd_byte = {4'h0, cause};
      else if (i_wb_adr == rst_wdt_pkg::ADDR_WDT_CTRL)
         rd_byte = {flag, irq_en_eff, watchdog_prescaler[3], chg_en, wde_eff,
                    watchdog_prescaler[2:0]};
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end
      else if (i_ce)
      begin
         o_wb_ack <= i_wb_cyc & i_wb_stb & !o_wb_ack;
         if (i_wb_cyc && i_wb_stb && !o_wb_ack)
            o_wb_dat <= {24'h000000, rd_byte};
      end
   end

   // ************************************************************
   // reset cause flags
   // ************************************************************
   assign cause_set = {wdt_rst_pulse, bod_hit, ext_active,
                       i_power_low};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_cause
         always_ff @(posedge i_clk)
         begin
            if (!i_rstn)
               cause[gi] <= rst_wdt_pkg::RESET_CAUSE_INIT[gi];
            else if (i_ce)
            begin
               // a new event beats a write of zero in the same cycle
               if (cause_set[gi])
                  cause[gi] <= 1'b1;
               else if ((wr_cause && !wd[gi])
                        || (gi != rst_wdt_pkg::CAUSE_POR
                            && i_power_low))
                  cause[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ************************************************************
   // watchdog control register
   // ************************************************************
   assign wde_eff    = watchdog_reset_enable | cause[rst_wdt_pkg::CAUSE_WDT]
                       | i_watchdog_always_on_fuse;
   assign irq_en_eff = irq_en & !i_watchdog_always_on_fuse;
   assign unlock_wr  = wr_ctrl & wd[rst_wdt_pkg::CTRL_CHG]
                       & wd[rst_wdt_pkg::CTRL_WDE];

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         chg_en  <= 1'b0;
         win_cnt <= 3'h0;
      end
      else if (i_ce)
      begin
         if (o_core_reset)
         begin
            chg_en  <= 1'b0;
            win_cnt <= 3'h0;
         end
         else if (unlock_wr)
         begin
            chg_en  <= 1'b1;
            win_cnt <= rst_wdt_pkg::UNLOCK_WINDOW;
         end
         else if (chg_en)
         begin
            win_cnt <= win_cnt - 3'h1;
            if (win_cnt == 3'h1 || wr_ctrl)
               chg_en <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         watchdog_reset_enable <= 1'b0;
         watchdog_prescaler <= rst_wdt_pkg::WDP_INIT;
      end
      else if (i_ce)
      begin
         if (o_core_reset)
         begin
            watchdog_reset_enable <= 1'b0;
            watchdog_prescaler <= rst_wdt_pkg::WDP_INIT;
         end
         else if (wr_ctrl && chg_en && !wd[rst_wdt_pkg::CTRL_CHG])
         begin
            watchdog_reset_enable <= wd[rst_wdt_pkg::CTRL_WDE]
                   | cause[rst_wdt_pkg::CAUSE_WDT];
            watchdog_prescaler <= {wd[rst_wdt_pkg::CTRL_WDP3], wd[2:0]};
         end
         else if (wr_ctrl && wd[rst_wdt_pkg::CTRL_WDE])
         begin
            // outside the window reset-enable can only be set
            watchdog_reset_enable <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         irq_en <= 1'b0;
      else if (i_ce)
      begin
         if (o_core_reset)
            irq_en <= 1'b0;
         else if (i_wdt_irq_ack && wde_eff)
            irq_en <= 1'b0;
         else if (wr_ctrl)
            irq_en <= wd[rst_wdt_pkg::CTRL_IRQEN];
      end
   end

   // ************************************************************
   // watchdog counter
   // ************************************************************
   assign running  = (wde_eff | irq_en_eff) & !o_core_reset;
   // the oscillator is sampled; one count per rising edge seen
   assign osc_edge = i_wdt_osc & !osc_q;
   // codes above the 8 s setting are held at the longest one
   assign wdp_sel  = (watchdog_prescaler > rst_wdt_pkg::WDP_MAX)
                     ? rst_wdt_pkg::WDP_MAX : watchdog_prescaler;
   assign wdt_limit = WDT_CW'((WDT_BASE << wdp_sel) - 1);
   assign timeout  = running & osc_edge
                     & (wdt_cnt == wdt_limit);

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         osc_q   <= 1'b0;
         wdt_cnt <= '0;
      end
      else if (i_ce)
      begin
         osc_q <= i_wdt_osc;
         // restart acts in the same cycle, so an edge cannot add to it
         if (!running || i_wdt_restart || timeout)
            wdt_cnt <= '0;
         else if (osc_edge)
            wdt_cnt <= wdt_cnt + WDT_CW'(1);
      end
   end

   // ************************************************************
   // time-out actions
   // ************************************************************
   always_comb
   begin
      set_flag = 1'b0;
      rst_hit  = 1'b0;
      if (timeout)
      begin
         if (irq_en_eff && !wde_eff)
            set_flag = 1'b1;
         else if (!irq_en_eff && wde_eff)
            rst_hit = 1'b1;
         else if (!flag)
            set_flag = 1'b1;
         else
            rst_hit = 1'b1;
      end
      next_flag = flag;
      if (set_flag)
         next_flag = 1'b1;
      else if (o_core_reset || i_wdt_irq_ack
               || (wr_ctrl && wd[rst_wdt_pkg::CTRL_FLAG]))
         next_flag = 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         flag          <= 1'b0;
         wdt_rst_pulse <= 1'b0;
         o_wdt_irq     <= 1'b0;
      end
      else if (i_ce)
      begin
         flag          <= next_flag;
         wdt_rst_pulse <= rst_hit;
         // also the wake request while the core sleeps
         o_wdt_irq     <= next_flag & irq_en_eff;
      end
   end

   // ************************************************************
   // voltage reference gate
   // ************************************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         o_vref_enable <= 1'b0;
      else if (i_ce)
         o_vref_enable <= bod_en | i_comparator_bandgap_select
                          | i_adc_enable;
   end

endmodule

// ---- verif/system_reset_and_watchdog_assertions.sv ----
`timescale 1ns/1ps
// ********
// port-level checks
// ********
module system_reset_and_watchdog_assertions
(
   input wire logic        i_clk,
   input wire logic        i_rstn,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic        o_wb_ack,
   input wire logic [31:0] o_wb_dat,
   input wire logic        i_power_low,
   input wire logic        i_reset_pin_n,
   input wire logic        i_brownout_low,
   input wire logic [1:0]  i_startup_time_fuse,
   input wire logic [3:0]  i_clock_select_fuse,
   input wire logic        i_reset_pin_disable_fuse,
   input wire logic [2:0]  i_brownout_level_fuse,
   input wire logic        i_watchdog_always_on_fuse,
   input wire logic        i_comparator_bandgap_select,
   input wire logic        i_adc_enable,
   input wire logic        i_wdt_irq_ack,
   input wire logic        o_core_reset,
   input wire logic        o_port_reset,
   input wire logic        o_wdt_irq,
   input wire logic        o_vref_enable
);
   logic        bod_on;
   logic        want_ref;
   logic        src;
   logic        mapped;
   logic [15:0] quiet;
   logic [8:0]  low_run;
   logic [15:0] dly;
   assign bod_on = i_brownout_level_fuse != rst_wdt_pkg::BOD_OFF;
   assign want_ref = bod_on | i_comparator_bandgap_select | i_adc_enable;
   assign src = i_power_low | (bod_on & i_brownout_low) |
                (!i_reset_pin_n & !i_reset_pin_disable_fuse);
   assign mapped = (i_wb_adr == rst_wdt_pkg::ADDR_RESET_CAUSE) ||
                   (i_wb_adr == rst_wdt_pkg::ADDR_WDT_CTRL);
   assign dly = rst_wdt_pkg::RELEASE_BASE_CYCLES <<
                ({1'b0, i_startup_time_fuse} +
                 {1'b0, i_clock_select_fuse[1:0]});
   // quiet counts from the last source; a watchdog pulse comes later,
   // so the bound below stays safe for it too
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || src)
         quiet <= 16'h0000;
      else if (quiet != 16'hFFFF)
         quiet <= quiet + 16'h0001;
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || i_reset_pin_n || i_reset_pin_disable_fuse)
         low_run <= 9'h000;
      else if (low_run != 9'h1FF)
         low_run <= low_run + 9'h001;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_ack_once;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   property p_ack_answer;
      s_req |=> s_ack_once;
   endproperty
   property p_read_data;
      o_wb_ack && !i_wb_we |->
         o_wb_dat[31:8] == 24'h000000 && (mapped || o_wb_dat[7:0] == 8'h00);
   endproperty
   property p_power_now;
      i_power_low |=> o_core_reset && o_port_reset;
   endproperty
   property p_bod_now;
      bod_on && i_brownout_low |=> o_core_reset && o_port_reset;
   endproperty
   property p_ext_pin;
      low_run >= 9'h104 |-> o_core_reset && o_port_reset;
   endproperty
   property p_release;
      $fell(o_core_reset) |-> quiet >= dly;
   endproperty
   property p_vref;
      1'b1 |=> o_vref_enable == $past(want_ref);
   endproperty
   property p_always_on;
      o_wb_ack && !i_wb_we && i_watchdog_always_on_fuse &&
      i_wb_adr == rst_wdt_pkg::ADDR_WDT_CTRL |-> o_wb_dat[3] && !o_wb_dat[6];
   endproperty
   property p_irq_ack;
      i_wdt_irq_ack |-> ##2 !o_wdt_irq;
   endproperty
   property p_irq_in_reset;
      o_core_reset [*4] |-> !o_wdt_irq;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("ack not a single pulse after request");
   a_read_data: assert property (p_read_data)
      else $error("read data outside the byte lane or unmapped");
   a_power_now: assert property (p_power_now)
      else $error("power low did not reset at once");
   a_bod_now: assert property (p_bod_now)
      else $error("brown-out did not reset at once");
   a_ext_pin: assert property (p_ext_pin)
      else $error("long pin pulse gave no reset");
   a_release: assert property (p_release)
      else $error("core released before the delay");
   a_vref: assert property (p_vref)
      else $error("reference enable wrong");
   a_always_on: assert property (p_always_on)
      else $error("always-on fuse not forcing enables");
   a_irq_ack: assert property (p_irq_ack)
      else $error("interrupt stays after vector");
   a_irq_in_reset: assert property (p_irq_in_reset)
      else $error("interrupt during core reset");
endmodule

bind system_reset_and_watchdog system_reset_and_watchdog_assertions chk (.*);

// ---- verif/core_side_model.sv ----
`timescale 1ns/1ps
// ********
// watchdog oscillator and interrupt vector fetch
// ********
module core_side_model
#(
   parameter int OSC_HALF = 4
)
(
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_auto_ack,
   input  wire logic i_irq,
   output logic      o_osc,
   output logic      o_irq_ack
);
   logic [7:0] div;
   logic [1:0] lag;
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         div <= 8'h00;
         o_osc <= 1'b0;
      end
      else if (div == 8'(OSC_HALF - 1))
      begin
         div <= 8'h00;
         o_osc <= !o_osc;
      end
      else
         div <= div + 8'h01;
   end
   // vector runs a few cycles late, once per request
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         lag <= 2'h0;
         o_irq_ack <= 1'b0;
      end
      else
      begin
         o_irq_ack <= (lag == 2'h2);
         if (lag == 2'h0)
            lag <= {1'b0, i_irq & i_auto_ack};
         else if (lag != 2'h3)
            lag <= lag + 2'h1;
         else if (!i_irq)
            lag <= 2'h0;
      end
   end
endmodule

// ---- verif/system_reset_and_watchdog_tb.sv ----
`timescale 1ns/1ps
module system_reset_and_watchdog_tb;
   localparam int WB = 16;
   localparam logic [7:0] CA = rst_wdt_pkg::ADDR_RESET_CAUSE;
   localparam logic [7:0] CT = rst_wdt_pkg::ADDR_WDT_CTRL;
   logic        i_clk = 1'b0;
   logic        i_rstn, i_ce, i_wb_cyc, i_wb_stb, i_wb_we;
   logic [7:0]  i_wb_adr, rd;
   logic [3:0]  i_wb_sel, i_clock_select_fuse;
   logic [31:0] i_wb_dat, o_wb_dat;
   logic        o_wb_ack, i_power_low, i_reset_pin_n, i_brownout_low;
   logic [1:0]  i_startup_time_fuse;
   logic        i_reset_pin_disable_fuse, i_watchdog_always_on_fuse;
   logic [2:0]  i_brownout_level_fuse;
   logic        i_comparator_bandgap_select, i_adc_enable, i_wdt_osc;
   logic        i_wdt_restart, i_wdt_irq_ack, o_core_reset, o_port_reset;
   logic        o_wdt_irq, o_vref_enable, auto_ack;
   logic        osc_d = 1'b0;
   integer      seed = 78268;
   int          bad_count = 0;
   int          n_checks = 0;
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) osc_d <= i_wdt_osc;
   system_reset_and_watchdog #(.WDT_BASE(WB), .WDT_CW(21)) uut (.*);
   core_side_model #(.OSC_HALF(4)) core (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_auto_ack(auto_ack), .i_irq(o_wdt_irq), .o_osc(i_wdt_osc),
      .o_irq_ack(i_wdt_irq_ack));
   // ********
   // helpers
   // ********
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic hang(input int g, input int lim);
      if (g >= lim)
      begin
         bad_count++;
         test_done();
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
      int t;
      t = 0;
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_dat <= {24'h000000, d};
      do
      begin
         @(posedge i_clk);
         t++;
      end while (o_wb_ack !== 1'b1 && t < 50);
      hang(t, 50);
      rd = o_wb_dat[7:0];
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, e);
   endtask
   task automatic wait_for(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 5000)
      begin
         @(posedge i_clk);
         n++;
      end
      hang(n, 5000);
   endtask
   task automatic kick;
      i_wdt_restart <= 1'b1;
      @(posedge i_clk);
      i_wdt_restart <= 1'b0;
   endtask
   task automatic wd_set(input logic [7:0] v);
      auto_ack <= 1'b0;
      wr(CT, 8'h18);
      wr(CT, v);
   endtask
   // restart right after an oscillator edge, then count edges to expiry
   task automatic irq_rises(output int n);
      int g;
      g = 0;
      while (!(i_wdt_osc && !osc_d) && g < 20)
      begin
         @(posedge i_clk);
         g++;
      end
      kick();
      n = 0;
      while (o_wdt_irq !== 1'b1 && g < 3000)
      begin
         @(posedge i_clk);
         g++;
         if (i_wdt_osc && !osc_d)
            n++;
      end
      hang(g, 3000);
   endtask
   // ********
   // scenarios
   // ********
   initial
   begin
      int n;
      logic [31:0] e;
      logic [2:0] f;
      i_rstn = 1'b0;
      i_ce = 1'b1;
      i_wb_cyc = 1'b0;
      i_wb_stb = 1'b0;
      i_wb_we = 1'b0;
      i_wb_adr = 8'h00;
      i_wb_sel = 4'hF;
      i_wb_dat = 32'h00000000;
      i_power_low = 1'b0;
      i_reset_pin_n = 1'b1;
      i_brownout_low = 1'b0;
      i_startup_time_fuse = 2'h0;
      i_clock_select_fuse = 4'h0;
      i_reset_pin_disable_fuse = 1'b0;
      i_brownout_level_fuse = 3'h7;
      i_watchdog_always_on_fuse = 1'b0;
      i_comparator_bandgap_select = 1'b0;
      i_adc_enable = 1'b0;
      i_wdt_restart = 1'b0;
      auto_ack = 1'b1;
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      wait_for(o_core_reset, 1'b0, n);
      chk(n >= 64, 1'b1);
      rc(CA, 8'h01);
      rc(CT, 8'h00);
      wr(CA, 8'h00);
      rc(CA, 8'h00);
      bus(1'b0, 8'h08, 8'h00);
      repeat (20)
      begin
         e = $random(seed);
         f = e[2] ? 3'h7 : e[5:3];
         i_comparator_bandgap_select <= e[0];
         i_adc_enable <= e[1];
         i_brownout_level_fuse <= f;
         repeat (2) @(posedge i_clk);
         chk(o_vref_enable, e[0] | e[1] | (f != 3'h7));
      end
      i_brownout_level_fuse <= 3'h7;
      for (int p = 0; p < 4; p++)
      begin
         // restart first so no time-out lands inside the setup writes
         kick();
         wd_set(8'h40 | 8'(p));
         rc(CT, 8'h40 | 8'(p));
         irq_rises(n);
         chk(n, WB << p);
         chk(o_core_reset, 1'b0);
         auto_ack <= 1'b1;
         repeat (8) @(posedge i_clk);
         rc(CT, 8'h40 | 8'(p));
      end
      auto_ack <= 1'b0;
      wr(CT, 8'h58);
      repeat (4) @(posedge i_clk);
      wr(CT, 8'h40);
      rc(CT, 8'h4B);
      wait_for(o_wdt_irq, 1'b1, n);
      chk(o_core_reset, 1'b0);
      wait_for(o_core_reset, 1'b1, n);
      chk(o_core_reset, 1'b1);
      wait_for(o_core_reset, 1'b0, n);
      kick();
      rc(CA, 8'h08);
      rc(CT, 8'h08);
      wd_set(8'h00);
      rc(CT, 8'h08);
      kick();
      wr(CA, 8'h00);
      wd_set(8'h00);
      rc(CT, 8'h00);
      i_watchdog_always_on_fuse <= 1'b1;
      kick();
      rc(CT, 8'h08);
      wr(CT, 8'h40);
      rc(CT, 8'h08);
      wr(CT, 8'h00);
      i_watchdog_always_on_fuse <= 1'b0;
      i_reset_pin_disable_fuse <= 1'b1;
      i_reset_pin_n <= 1'b0;
      repeat (300) @(posedge i_clk);
      chk(o_core_reset, 1'b0);
      i_reset_pin_disable_fuse <= 1'b0;
      i_startup_time_fuse <= 2'h1;
      i_clock_select_fuse <= 4'h1;
      repeat (300) @(posedge i_clk);
      chk(o_core_reset, 1'b1);
      i_reset_pin_n <= 1'b1;
      wait_for(o_core_reset, 1'b0, n);
      chk(n >= 256 && n <= 264, 1'b1);
      rc(CA, 8'h02);
      i_brownout_low <= 1'b1;
      repeat (20) @(posedge i_clk);
      chk(o_core_reset, 1'b0);
      i_brownout_level_fuse <= 3'h4;
      repeat (3) @(posedge i_clk);
      chk(o_core_reset, 1'b1);
      i_brownout_low <= 1'b0;
      wait_for(o_core_reset, 1'b0, n);
      rc(CA, 8'h06);
      i_power_low <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk(o_core_reset, 1'b1);
      i_power_low <= 1'b0;
      wait_for(o_core_reset, 1'b0, n);
      rc(CA, 8'h01);
      test_done();
   end
endmodule
